// ==== hdl/mtid_cfg.svh ====
/*
  Constants of the test port instruction decode: codes, widths, patterns
  and reset values.
  Assumes it is included by bare name and compiled before the package.
*/
// What this block does
// - Code 000 puts boundary register in path.
// - Code 001 loads and shifts the identification word.
// - Identification code loaded at power-up and reset state.
// - Code 010 samples ring, floats outputs except echo.
// - Code 100 samples ring, outputs stay normal.
// - Code 111 routes through single bypass bit.
// - Codes are binary, most significant bit leftmost.
// - Instruction register is three bits wide.
// - Capture-IR loads 01 into low bits.
// - New instruction acts only after Update-IR.
// - Identification bit 0 leaves first on output.
`ifndef MTID_CFG_SVH
`define MTID_CFG_SVH

`define MTID_IR_LEN 3
`define MTID_BSR_LEN 8
`define MTID_ID_LEN 32

`define MTID_OP_EXTEST 3'h0
`define MTID_OP_IDCODE 3'h1
`define MTID_OP_SAMPLE_Z 3'h2
`define MTID_OP_SAMPLE 3'h4
`define MTID_OP_BYPASS 3'h7

`define MTID_IR_CAPTURE 3'h1
`define MTID_BYP_CAPTURE 1'h0
`define MTID_TDO_RST 1'h0
`define MTID_BSR_RST 8'h00

`endif

// ==== hdl/mtid_pkg.sv ====
/*
  Types shared by the test port modules.
  Assumes the constants header is on the include path.
*/
`include "mtid_cfg.svh"

package mtid_pkg;

  typedef logic [`MTID_IR_LEN-1:0] mtid_ir_t;
  typedef logic [`MTID_BSR_LEN-1:0] mtid_bsr_t;
  typedef logic [`MTID_ID_LEN-1:0] mtid_id_t;

  // Gray codes along the usual walk through the state diagram.
  typedef enum logic [3:0] {
    MTID_TLR = 4'h0,
    MTID_RTI = 4'h1,
    MTID_SEL_DR = 4'h3,
    MTID_CAP_DR = 4'h2,
    MTID_SH_DR = 4'h6,
    MTID_EX1_DR = 4'h7,
    MTID_PA_DR = 4'h5,
    MTID_EX2_DR = 4'h4,
    MTID_UP_DR = 4'hC,
    MTID_SEL_IR = 4'hD,
    MTID_CAP_IR = 4'hF,
    MTID_SH_IR = 4'hE,
    MTID_EX1_IR = 4'hA,
    MTID_PA_IR = 4'hB,
    MTID_EX2_IR = 4'h9,
    MTID_UP_IR = 4'h8
  } mtid_tap_st_t;

  typedef enum logic [1:0] {
    MTID_PATH_BSR = 2'h0,
    MTID_PATH_ID = 2'h1,
    MTID_PATH_BYP = 2'h2
  } mtid_dr_sel_t;

endpackage

// ==== hdl/mtid_ir_if.sv ====
/*
  Carrier between the test port controller and its instruction decoder.
  Assumes both ends import the shared package.
*/
`timescale 1ns/1ps

interface mtid_ir_if;
  import mtid_pkg::*;

  mtid_ir_t act;
  mtid_dr_sel_t dr_sel;
  logic hiz;
  logic cap_ring;

  modport tap (output act, input dr_sel, input hiz, input cap_ring);
  modport dec (input act, output dr_sel, output hiz, output cap_ring);
endinterface

// ==== hdl/mtid_decode.sv ====
/*
  Instruction decoder: turns the active instruction into a data path
  choice, an output float request and a ring capture request.
  Assumes the active instruction is a registered value of the test clock.
*/
`timescale 1ns/1ps
`include "mtid_cfg.svh"

module mtid_decode (
  mtid_ir_if.dec ir
);
  import mtid_pkg::*;

  function automatic mtid_dr_sel_t path_of(input mtid_ir_t op);
    mtid_dr_sel_t sel;
    sel = MTID_PATH_BYP;
    case (op)
      `MTID_OP_EXTEST: sel = MTID_PATH_BSR;
      `MTID_OP_IDCODE: sel = MTID_PATH_ID;
      `MTID_OP_SAMPLE_Z: sel = MTID_PATH_BSR;
      `MTID_OP_SAMPLE: sel = MTID_PATH_BSR;
      `MTID_OP_BYPASS: sel = MTID_PATH_BYP;
      // private codes fall back to bypass.
      default: sel = MTID_PATH_BYP;
    endcase
    return sel;
  endfunction

  always_comb begin
    ir.dr_sel = path_of(ir.act);
    // outputs float only for this code.
    ir.hiz = (ir.act == `MTID_OP_SAMPLE_Z);
    ir.cap_ring = (path_of(ir.act) == MTID_PATH_BSR);
  end
endmodule

// ==== hdl/mtid_tap.sv ====
/*
  Test access port of the memory: state machine, instruction register,
  boundary, identification and bypass registers, and the serial output.
  The serial logic runs on the test clock; the output float request is
  carried into the memory clock domain by a two flop synchroniser.
  Assumes the test clock is unrelated to clk_i and may stop between
  operations; tms and tdi are launched by the controller on that clock.
*/
`timescale 1ns/1ps
`include "mtid_cfg.svh"

module mtid_tap #(
  // Identification word; the value is arbitrary, bit 0 set as required.
  parameter mtid_pkg::mtid_id_t ID_CODE = 32'h0A5A_0001
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire mtid_pkg::mtid_bsr_t ring_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  output logic mem_drv_en_o,
  output logic echo_clk_drv_en_o
);
  import mtid_pkg::*;

  mtid_ir_if ir ();

  mtid_decode u_decode (
    .ir(ir.dec)
  );

  // Power-up request carried into the test clock domain.
  logic rst_m;
  logic rst_s;
  logic por;
  // Pin ring carried into the test clock domain.
  mtid_bsr_t ring_m;
  mtid_bsr_t ring_s;

  always_ff @(posedge tck_i) begin
    rst_m <= reset_i;
    rst_s <= rst_m;
    ring_m <= ring_i;
    ring_s <= ring_m;
  end

  assign por = rst_s;

  mtid_tap_st_t st;
  mtid_tap_st_t next_st;
  mtid_ir_t ir_sh;
  mtid_ir_t next_ir_sh;
  mtid_ir_t act;
  mtid_ir_t next_act;
  mtid_bsr_t bsr;
  mtid_bsr_t next_bsr;
  mtid_id_t idr;
  mtid_id_t next_idr;
  logic byp;
  logic next_byp;
  logic hiz_q;
  logic next_hiz_q;

  assign ir.act = act;

  always_comb begin
    next_st = MTID_TLR;
    case (st)
      MTID_TLR: next_st = tms_i ? MTID_TLR : MTID_RTI;
      MTID_RTI: next_st = tms_i ? MTID_SEL_DR : MTID_RTI;
      MTID_SEL_DR: next_st = tms_i ? MTID_SEL_IR : MTID_CAP_DR;
      MTID_CAP_DR: next_st = tms_i ? MTID_EX1_DR : MTID_SH_DR;
      MTID_SH_DR: next_st = tms_i ? MTID_EX1_DR : MTID_SH_DR;
      MTID_EX1_DR: next_st = tms_i ? MTID_UP_DR : MTID_PA_DR;
      MTID_PA_DR: next_st = tms_i ? MTID_EX2_DR : MTID_PA_DR;
      MTID_EX2_DR: next_st = tms_i ? MTID_UP_DR : MTID_SH_DR;
      MTID_UP_DR: next_st = tms_i ? MTID_SEL_DR : MTID_RTI;
      MTID_SEL_IR: next_st = tms_i ? MTID_TLR : MTID_CAP_IR;
      MTID_CAP_IR: next_st = tms_i ? MTID_EX1_IR : MTID_SH_IR;
      MTID_SH_IR: next_st = tms_i ? MTID_EX1_IR : MTID_SH_IR;
      MTID_EX1_IR: next_st = tms_i ? MTID_UP_IR : MTID_PA_IR;
      MTID_PA_IR: next_st = tms_i ? MTID_EX2_IR : MTID_PA_IR;
      MTID_EX2_IR: next_st = tms_i ? MTID_UP_IR : MTID_SH_IR;
      MTID_UP_IR: next_st = tms_i ? MTID_SEL_DR : MTID_RTI;
      default: next_st = MTID_TLR;
    endcase
  end

  always_comb begin
    next_ir_sh = ir_sh;
    next_act = act;
    next_bsr = bsr;
    next_idr = idr;
    next_byp = byp;
    next_hiz_q = ir.hiz;
    case (st)
      // reset state restores the identification code.
      MTID_TLR: begin
        next_act = `MTID_OP_IDCODE;
        next_hiz_q = 1'h0;
      end
      MTID_CAP_IR: next_ir_sh = `MTID_IR_CAPTURE;
      // three bit shift, first bit in ends lowest.
      MTID_SH_IR: next_ir_sh = {tdi_i, ir_sh[`MTID_IR_LEN-1:1]};
      MTID_UP_IR: begin
        next_act = ir_sh;
        // float request follows the new code at once.
        // The test clock may stop right after update.
        next_hiz_q = (ir_sh == `MTID_OP_SAMPLE_Z);
      end
      MTID_CAP_DR: begin
        next_byp = `MTID_BYP_CAPTURE;
        // identification word preloaded from the fixed code.
        next_idr = ID_CODE;
        // ring sampled into the boundary register.
        if (ir.cap_ring) begin
          next_bsr = ring_s;
        end
      end
      MTID_SH_DR: begin
        case (ir.dr_sel)
          // boundary register shifts between tdi and tdo.
          MTID_PATH_BSR: next_bsr = {tdi_i, bsr[`MTID_BSR_LEN-1:1]};
          // lowest bit moves toward tdo first.
          MTID_PATH_ID: next_idr = {tdi_i, idr[`MTID_ID_LEN-1:1]};
          // single bit between tdi and tdo.
          MTID_PATH_BYP: next_byp = tdi_i;
          default: next_byp = tdi_i;
        endcase
      end
      default: next_act = act;
    endcase
  end

  always_ff @(posedge tck_i) begin
    if (por) begin
      st <= MTID_TLR;
      ir_sh <= `MTID_IR_CAPTURE;
      act <= `MTID_OP_IDCODE;
      bsr <= `MTID_BSR_RST;
      idr <= ID_CODE;
      byp <= `MTID_BYP_CAPTURE;
      hiz_q <= 1'h0;
    end else begin
      st <= next_st;
      ir_sh <= next_ir_sh;
      act <= next_act;
      bsr <= next_bsr;
      idr <= next_idr;
      byp <= next_byp;
      hiz_q <= next_hiz_q;
    end
  end

  // Serial output changes on the falling test clock edge so the
  // controller samples a settled bit on the next rising edge.
  logic next_tdo;
  logic next_tdo_oe;

  always_comb begin
    next_tdo = `MTID_TDO_RST;
    next_tdo_oe = 1'h0;
    if (st == MTID_SH_IR) begin
      next_tdo = ir_sh[0];
      next_tdo_oe = 1'h1;
    end else if (st == MTID_SH_DR) begin
      next_tdo_oe = 1'h1;
      case (ir.dr_sel)
        MTID_PATH_BSR: next_tdo = bsr[0];
        // bit 0 of the identification word drives tdo.
        MTID_PATH_ID: next_tdo = idr[0];
        MTID_PATH_BYP: next_tdo = byp;
        default: next_tdo = byp;
      endcase
    end
  end

  always_ff @(negedge tck_i) begin
    if (por) begin
      tdo_o <= `MTID_TDO_RST;
      tdo_oe_o <= 1'h0;
    end else begin
      tdo_o <= next_tdo;
      tdo_oe_o <= next_tdo_oe;
    end
  end

  // Float request crosses into the memory clock domain.
  logic hiz_m;
  logic hiz_s;
  logic next_mem_drv_en;

  always_ff @(posedge clk_i) begin
    hiz_m <= hiz_q;
    hiz_s <= hiz_m;
  end

  always_comb begin
    // data drivers float, echo clock driver never does.
    next_mem_drv_en = ~hiz_s;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mem_drv_en_o <= 1'h1;
      echo_clk_drv_en_o <= 1'h1;
    end else begin
      mem_drv_en_o <= next_mem_drv_en;
      echo_clk_drv_en_o <= 1'h1;
    end
  end

  a_bsr_capture_load: assert property (
    @(posedge tck_i) disable iff (por)
    (st == MTID_CAP_DR && act == `MTID_OP_EXTEST)
      |=> bsr == $past(ring_s))
    else $error("boundary register missed the ring capture");

  a_bsr_shift_in: assert property (
    @(posedge tck_i) disable iff (por)
    (st == MTID_SH_DR && act == `MTID_OP_EXTEST)
      |=> bsr[`MTID_BSR_LEN-1] == $past(tdi_i))
    else $error("boundary register did not shift tdi in");

  a_id_preload_value: assert property (
    @(posedge tck_i) disable iff (por)
    (st == MTID_CAP_DR && act == `MTID_OP_IDCODE) |=> idr == ID_CODE)
    else $error("identification word not preloaded");

  a_reset_default_op: assert property (
    @(posedge tck_i) disable iff (por)
    st == MTID_TLR |=> act == `MTID_OP_IDCODE)
    else $error("reset state did not restore the default code");

  a_samplez_float_out: assert property (
    @(posedge clk_i) disable iff (reset_i)
    $past(hiz_s, 2) && $past(hiz_s, 1) |-> !mem_drv_en_o
      && echo_clk_drv_en_o)
    else $error("drivers not floated or echo clock dropped");

  a_samplez_path_sel: assert property (
    @(posedge tck_i) disable iff (por)
    act == `MTID_OP_SAMPLE_Z |-> ir.hiz && ir.dr_sel == MTID_PATH_BSR)
    else $error("floating sample decoded wrongly");

  a_sample_keep_drive: assert property (
    @(posedge tck_i) disable iff (por)
    (st == MTID_CAP_DR && act == `MTID_OP_SAMPLE)
      |=> bsr == $past(ring_s) && !hiz_q)
    else $error("sample did not capture or floated outputs");

  a_bypass_one_bit: assert property (
    @(posedge tck_i) disable iff (por)
    (st == MTID_SH_DR && act == `MTID_OP_BYPASS && !tms_i)
      |=> tdo_o == $past(tdi_i) && tdo_oe_o)
    else $error("bypass path is not one bit long");

  a_code_bit_order: assert property (
    @(posedge tck_i) disable iff (por)
    st == MTID_UP_IR |=> act == $past(ir_sh))
    else $error("instruction bit order broken");

  a_ir_shift_three: assert property (
    @(posedge tck_i) disable iff (por)
    st == MTID_SH_IR |=> ir_sh == {$past(tdi_i), $past(ir_sh[2:1])})
    else $error("instruction register shift wrong");

  a_ir_capture_pat: assert property (
    @(posedge tck_i) disable iff (por)
    st == MTID_CAP_IR |=> ir_sh[1:0] == 2'h1)
    else $error("capture pattern not 01");

  a_ir_update_only: assert property (
    @(posedge tck_i) disable iff (por)
    (st != MTID_UP_IR && st != MTID_TLR) |=> $stable(act))
    else $error("instruction changed outside update");

  a_id_lsb_first: assert property (
    @(posedge tck_i) disable iff (por)
    (st == MTID_SH_DR && act == `MTID_OP_IDCODE && !tms_i)
      |=> tdo_o == $past(idr[1]))
    else $error("identification word not sent lowest bit first");

  a_hiz_at_update: assert property (
    @(posedge tck_i) disable iff (por)
    st == MTID_UP_IR
      |=> hiz_q == ($past(ir_sh) == `MTID_OP_SAMPLE_Z))
    else $error("float request did not follow the updated code");

  a_id_first_bit: assert property (
    @(posedge tck_i) disable iff (por)
    (st == MTID_CAP_DR && act == `MTID_OP_IDCODE && !tms_i)
      |=> tdo_o == ID_CODE[0] && tdo_oe_o)
    else $error("first identification bit is not bit 0");

  a_tdo_shift_only: assert property (
    @(posedge tck_i) disable iff (por)
    tdo_oe_o == (st == MTID_SH_IR || st == MTID_SH_DR))
    else $error("serial output enabled outside a shift state");

endmodule

// ==== dv/mtid_ctl_model.sv ====
/*
  Behavioural board test controller that drives the test port serially.
  Assumes the bench calls step once for each test clock period it wants.
*/
`timescale 1ns/1ps

module mtid_ctl_model (
  input wire logic tdo_i,
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o
);
  initial begin
    tck_o = 1'h0;
    tms_o = 1'h1;
    tdi_o = 1'h0;
  end

  // one bit per call, clock stands low between calls.
  task automatic step(input logic m, input logic d, output logic o);
    tms_o = m;
    tdi_o = d;
    #7.5;
    o = tdo_i;
    tck_o = 1'h1;
    #7.5;
    tck_o = 1'h0;
  endtask
endmodule

// ==== dv/memory_tap_instruction_decode_tb.sv ====
/*
  Self-checking bench of the test port: instruction loads, data paths,
  output float and resets of the test logic.
  Assumes the controller model in its own file and a 15 ns test clock.
*/
`timescale 1ns/1ps

`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  failures++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
  end end

module memory_tap_instruction_decode_tb;
  import mtid_pkg::*;
  // Identification word; the value is arbitrary.
  localparam mtid_id_t ID = 32'h1234_5679;
  logic clk_i, reset_i, tck, tms, tdi, tdo, tdo_oe, mem_en, echo_en, o;
  mtid_bsr_t ring;
  mtid_ir_t cap, act;
  logic [31:0] got, din;
  int failures, cmp_count, seed;
  // the controller never loads the private codes.
  mtid_ir_t codes [5] = '{3'h7, 3'h0, 3'h4, 3'h1, 3'h2};

  mtid_tap #(.ID_CODE(ID)) u_mtid_tap (.clk_i(clk_i), .reset_i(reset_i),
    .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .ring_i(ring), .tdo_o(tdo),
    .tdo_oe_o(tdo_oe), .mem_drv_en_o(mem_en), .echo_clk_drv_en_o(echo_en));
  mtid_ctl_model u_mtid_ctl_model (.tdo_i(tdo), .tck_o(tck), .tms_o(tms),
    .tdi_o(tdi));

  initial begin
    clk_i = 1'h0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic ir_end(input bit paused);
    logic b;
    if (paused) u_mtid_ctl_model.step(1'h1, 1'h0, b);
    u_mtid_ctl_model.step(1'h1, 1'h0, b);
    u_mtid_ctl_model.step(1'h0, 1'h0, b);
  endtask

  // Loads from Run-Test/Idle; without update it parks in Pause-IR.
  task automatic ir_load(input mtid_ir_t code, input bit upd,
                         output mtid_ir_t c);
    logic b;
    u_mtid_ctl_model.step(1'h1, 1'h0, b);
    u_mtid_ctl_model.step(1'h1, 1'h0, b);
    u_mtid_ctl_model.step(1'h0, 1'h0, b);
    u_mtid_ctl_model.step(1'h0, 1'h0, b);
    for (int i = 0; i < 3; i++) begin
      u_mtid_ctl_model.step(i == 2, code[i], b);
      c[i] = b;
    end
    if (upd) ir_end(1'b0);
    else u_mtid_ctl_model.step(1'h0, 1'h0, b);
  endtask

  task automatic dr_shift(input int n, input logic [31:0] d,
                          output logic [31:0] q);
    logic b;
    q = 32'h0;
    u_mtid_ctl_model.step(1'h1, 1'h0, b);
    u_mtid_ctl_model.step(1'h0, 1'h0, b);
    u_mtid_ctl_model.step(1'h0, 1'h0, b);
    for (int i = 0; i < n; i++) begin
      u_mtid_ctl_model.step(i == n - 1, d[i], b);
      q[i] = b;
    end
    u_mtid_ctl_model.step(1'h1, 1'h0, b);
    u_mtid_ctl_model.step(1'h0, 1'h0, b);
  endtask

  function automatic logic [31:0] expect_dr(mtid_ir_t c, mtid_bsr_t r,
                                            logic [31:0] d);
    case (c)
      3'h1: return ID;
      3'h7: return {24'h0, d[6:0], 1'h0};
      default: return {24'h0, r};
    endcase
  endfunction

  task automatic wait_clk();
    repeat (10) @(posedge clk_i);
    #1;
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #500000;
    failures++;
    complete_run();
  end

  initial begin
    seed = 45;
    failures = 0;
    cmp_count = 0;
    reset_i = 1'h1;
    ring = 8'h00;
    act = 3'h1;
    fork
      repeat (4) @(posedge clk_i);
      repeat (4) u_mtid_ctl_model.step(1'h1, 1'h0, o);
    join
    @(posedge clk_i);
    #1 reset_i = 1'h0;
    repeat (2) u_mtid_ctl_model.step(1'h1, 1'h0, o);
    u_mtid_ctl_model.step(1'h0, 1'h0, o);
    wait_clk();
    dr_shift(32, 32'($random(seed)), got);
    `CHK("power_up_id", ID, got)
    `CHK("mem_drv_en", 1'h1, mem_en)
    repeat (3) begin
      for (int k = 0; k < 5; k++) begin
        @(posedge clk_i);
        #1 ring = 8'($random(seed));
        ir_load(codes[k], 1'b0, cap);
        `CHK("ir_capture", 3'h1, cap)
        wait_clk();
        `CHK("mem_drv_en_held", act !== 3'h2, mem_en)
        `CHK("tdo_oe_idle", 1'h0, tdo_oe)
        ir_end(1'b1);
        act = codes[k];
        wait_clk();
        `CHK("mem_drv_en", act !== 3'h2, mem_en)
        `CHK("echo_clk_drv_en", 1'h1, echo_en)
        din = 32'($random(seed));
        dr_shift((act == 3'h1) ? 32 : 8, din, got);
        `CHK("dr_path", expect_dr(act, ring, din), got)
      end
    end
    // five high test mode bits return the default instruction.
    repeat (5) u_mtid_ctl_model.step(1'h1, 1'h0, o);
    u_mtid_ctl_model.step(1'h0, 1'h0, o);
    wait_clk();
    `CHK("tlr_mem_drv_en", 1'h1, mem_en)
    dr_shift(32, 32'($random(seed)), got);
    `CHK("tlr_id", ID, got)
    complete_run();
  end
endmodule
